// File: hw/cetu_defines.vh
// Summary of operation
// RL1 - FP unimplemented: decode, compute address, take F-line
// RL2 - FP frame holds address, fault PC, next PC
// RL3 - FP frame stacked PC is next instruction
// RL4 - Privileged instruction in user mode faults
// RL5 - Privilege: copy status, supervisor, clear trace, vector 8
// RL6 - Privilege stacked PC is offending instruction
// RL7 - Trace bits sampled at instruction start decide
// RL8 - Trace modes: off, flow, all, reserved
// RL9 - Flow mode traces jumps, returns, status writes
// RL10 - Suspended traced instruction defers trace until completion
// RL11 - Trace processed before pending interrupt
// RL12 - Forced exception first, trace afterwards
// RL13 - Illegal or unimplemented instruction never traced
// RL14 - Trace: supervisor, clear trace, vector 9, next PC
// RL15 - Traced stop loads status, traces, never stops (code: trace-all mode only; in flow mode a stop stops and is not traced)
// RL16 - Return checks frame format, error uses vector 14
// RL17 - Format error stacks detecting instruction PC
// RL18 - F-line class exception uses vector 11
// RL19 - Vector offset is vector times four
`ifndef CETU_DEFINES_VH
`define CETU_DEFINES_VH

// Vector numbers
`define CETU_VEC_PRIV      8'h08
`define CETU_VEC_TRACE     8'h09
`define CETU_VEC_FLINE     8'h0B
`define CETU_VEC_FORMAT    8'h0E

// Status word bit positions
`define CETU_SR_TALL       15
`define CETU_SR_TFLOW      14
`define CETU_SR_SUPER      13

// Trace modes {trace_all_bit, trace_flow_bit}
`define CETU_TR_OFF        2'h0
`define CETU_TR_FLOW       2'h1
`define CETU_TR_ALL        2'h2
`define CETU_TR_RSVD       2'h3

// Frame format codes
`define CETU_FMT_NORMAL    4'h0
`define CETU_FMT_FPEXT     4'h4

// Accepted frame formats, one bit per code
`define CETU_FMT_OK_MASK   16'h009F

// Next-instruction PC offset within the frame, in bytes
`define CETU_FRAME_PC_OFS  4'h2

`endif

// File: hw/cetu_exception_unit.v
`timescale 1ns/1ps
`include "cetu_defines.vh"

module cetu_exception_unit (
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_rst,
    // Instruction issue
    input  wire        i_insn_start,
    input  wire [31:0] i_insn_pc,
    input  wire [31:0] i_insn_next_pc,
    input  wire        i_insn_illegal,
    input  wire        i_insn_priv,
    input  wire        i_insn_fpu,
    input  wire        i_insn_flow,
    input  wire        i_insn_stop,
    input  wire        i_insn_rte,
    input  wire [3:0]  i_rte_format,
    // Effective address operands
    input  wire        i_ea_needed,
    input  wire [31:0] i_ea_base,
    input  wire [31:0] i_ea_disp,
    // Status word
    input  wire [15:0] i_status_word,
    input  wire [15:0] i_stop_status_word,
    // Instruction progress
    input  wire        i_insn_done,
    input  wire        i_insn_suspend,
    input  wire        i_insn_resume,
    input  wire        i_forced_exc,
    input  wire        i_forced_done,
    // Vector table base
    input  wire [31:0] i_vbr,
    // Exception handshake
    input  wire        i_exc_ack,
    output wire        o_exc_valid,
    output wire [7:0]  o_vector,
    output wire [9:0]  o_vec_offset,
    output wire [31:0] o_vec_addr,
    output wire [3:0]  o_frame_format,
    output wire [31:0] o_frame_pc,
    output wire [15:0] o_frame_status_word,
    output wire [31:0] o_frame_ea,
    output wire [31:0] o_frame_fault_pc,
    output wire [15:0] o_new_status_word,
    // Core control
    output wire        o_stop_enter,
    output wire        o_irq_hold
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_SUSP = 2'h2;
    localparam [1:0] ST_FWAIT = 2'h3;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg         due_ff;
    reg         nxt_due;
    reg  [31:0] npc_ff;
    reg  [31:0] nxt_npc;
    reg         valid_ff;
    reg         nxt_valid;
    reg  [7:0]  vec_ff;
    reg  [7:0]  nxt_vec;
    reg  [31:0] vaddr_ff;
    reg  [31:0] nxt_vaddr;
    reg  [3:0]  fmt_ff;
    reg  [3:0]  nxt_fmt;
    reg  [31:0] pc_ff;
    reg  [31:0] nxt_pc;
    reg  [15:0] sr_ff;
    reg  [15:0] nxt_sr;
    reg  [31:0] ea_ff;
    reg  [31:0] nxt_ea;
    reg  [31:0] fpc_ff;
    reg  [31:0] nxt_fpc;
    reg         stop_ff;
    reg         nxt_stop;

    reg         e_go;
    reg  [7:0]  e_vec;
    reg  [3:0]  e_fmt;
    reg  [31:0] e_pc;
    reg  [15:0] e_sr;
    reg  [31:0] e_ea;
    reg  [31:0] e_fpc;

    wire [1:0]  cur_mode;
    wire        user_mode;
    wire        fmt_bad;
    wire [31:0] calc_ea;
    wire        want_trace;
    wire [15:0] fmt_mask;
    wire [15:0] fmt_sel;

    assign cur_mode = {i_status_word[`CETU_SR_TALL], i_status_word[`CETU_SR_TFLOW]};
    assign user_mode = ~i_status_word[`CETU_SR_SUPER];
    assign fmt_mask = `CETU_FMT_OK_MASK;

    // One-hot select of the stacked format code
    assign fmt_sel = 16'h0001 << i_rte_format;
    assign fmt_bad = ~|(fmt_mask & fmt_sel); // RL16

    // Operand address from partial decode
    assign calc_ea = i_ea_needed ? (i_ea_base + i_ea_disp) : 32'h0000_0000; // RL1

    // Mode decode, reserved code traces nothing
    assign want_trace = (cur_mode == `CETU_TR_ALL) ||
                        ((cur_mode == `CETU_TR_FLOW) && i_insn_flow); // RL8 RL9

    always @* begin
        nxt_state = state_ff;
        nxt_due   = due_ff;
        nxt_npc   = npc_ff;
        nxt_stop  = 1'b0;
        e_go      = 1'b0;
        e_vec     = `CETU_VEC_TRACE;
        e_fmt     = `CETU_FMT_NORMAL;
        e_pc      = npc_ff;
        e_sr      = i_status_word;
        e_ea      = 32'h0000_0000;
        e_fpc     = 32'h0000_0000;
        case (state_ff)
            ST_IDLE: begin
                if (i_insn_start && !valid_ff) begin
                    if (i_insn_illegal) begin
                        // Core takes its own vector, nothing traced
                        nxt_due = 1'b0; // RL13
                    end else if (i_insn_priv && user_mode) begin
                        e_go  = 1'b1; // RL4 RL5
                        e_vec = `CETU_VEC_PRIV; // RL5
                        e_pc  = i_insn_pc; // RL6
                    end else if (i_insn_fpu) begin
                        e_go  = 1'b1; // RL1
                        e_vec = `CETU_VEC_FLINE; // RL18
                        e_fmt = `CETU_FMT_FPEXT; // RL2
                        e_ea  = calc_ea; // RL2
                        e_fpc = i_insn_pc; // RL2
                        e_pc  = i_insn_next_pc; // RL3
                    end else if (i_insn_rte && fmt_bad) begin
                        e_go  = 1'b1; // RL16
                        e_vec = `CETU_VEC_FORMAT; // RL16
                        e_fmt = `CETU_FMT_NORMAL; // RL16
                        e_pc  = i_insn_pc; // RL17
                    end else if (i_insn_stop && cur_mode == `CETU_TR_ALL) begin
                        // Status loaded, then trace instead of stopping
                        e_go  = 1'b1; // RL15
                        e_vec = `CETU_VEC_TRACE; // RL15
                        e_sr  = i_stop_status_word; // RL15
                        e_pc  = i_insn_next_pc; // RL15
                    end else begin
                        nxt_due   = want_trace; // RL7
                        nxt_npc   = i_insn_next_pc;
                        nxt_stop  = i_insn_stop;
                        nxt_state = i_insn_stop ? ST_IDLE : ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                if (i_insn_suspend) begin
                    nxt_state = ST_SUSP; // RL10
                end else if (i_insn_done) begin
                    if (due_ff && i_forced_exc) begin
                        nxt_state = ST_FWAIT; // RL12
                    end else begin
                        e_go      = due_ff; // RL14
                        nxt_due   = 1'b0;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_SUSP: begin
                if (i_insn_resume) begin
                    nxt_state = ST_EXEC; // RL10
                end
            end
            ST_FWAIT: begin
                if (i_forced_done && !valid_ff) begin
                    e_go      = 1'b1; // RL12
                    nxt_due   = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_due   = 1'b0;
            end
        endcase
    end

    always @* begin
        nxt_valid = valid_ff & ~i_exc_ack;
        nxt_vec   = vec_ff;
        nxt_vaddr = vaddr_ff;
        nxt_fmt   = fmt_ff;
        nxt_pc    = pc_ff;
        nxt_sr    = sr_ff;
        nxt_ea    = ea_ff;
        nxt_fpc   = fpc_ff;
        if (e_go) begin
            nxt_valid = 1'b1;
            nxt_vec   = e_vec;
            nxt_vaddr = i_vbr + {22'h00_0000, e_vec, 2'h0}; // RL19
            nxt_fmt   = e_fmt;
            nxt_pc    = e_pc;
            nxt_sr    = e_sr; // RL5 RL14
            nxt_ea    = e_ea;
            nxt_fpc   = e_fpc;
        end
    end

    // Sequencer state
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Trace owed by the running instruction
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            due_ff <= 1'b0;
        end else begin
            due_ff <= nxt_due;
        end
    end

    // Next-instruction address of the running instruction
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            npc_ff <= 32'h0000_0000;
        end else begin
            npc_ff <= nxt_npc;
        end
    end

    // Exception request, held until acknowledge
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= nxt_valid;
        end
    end

    // Vector number
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            vec_ff <= 8'h00;
        end else begin
            vec_ff <= nxt_vec;
        end
    end

    // Handler fetch address
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            vaddr_ff <= 32'h0000_0000;
        end else begin
            vaddr_ff <= nxt_vaddr;
        end
    end

    // Frame format code
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            fmt_ff <= 4'h0;
        end else begin
            fmt_ff <= nxt_fmt;
        end
    end

    // Stacked program counter
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pc_ff <= 32'h0000_0000;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // Stacked status copy
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sr_ff <= 16'h0000;
        end else begin
            sr_ff <= nxt_sr;
        end
    end

    // Stacked operand address
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ea_ff <= 32'h0000_0000;
        end else begin
            ea_ff <= nxt_ea;
        end
    end

    // Stacked faulting address
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            fpc_ff <= 32'h0000_0000;
        end else begin
            fpc_ff <= nxt_fpc;
        end
    end

    // Stop entry pulse
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            stop_ff <= 1'b0;
        end else begin
            stop_ff <= nxt_stop;
        end
    end

    // Frame and vector outputs
    assign o_exc_valid         = valid_ff;
    assign o_vector            = vec_ff;
    assign o_vec_offset        = {vec_ff, 2'h0}; // RL19
    assign o_vec_addr          = vaddr_ff; // RL19
    assign o_frame_format      = fmt_ff;
    assign o_frame_pc          = pc_ff;
    assign o_frame_status_word = sr_ff;
    assign o_frame_ea          = ea_ff;
    assign o_frame_fault_pc    = fpc_ff;

    // Supervisor entry with tracing disabled
    assign o_new_status_word = {2'h0, sr_ff[13:0]} |
                               16'h2000; // RL5 RL14

    // Untraced stop enters stopped state
    assign o_stop_enter = stop_ff; // RL15

    // Interrupts wait for outstanding trace
    assign o_irq_hold = (due_ff && state_ff != ST_IDLE) ||
                        (valid_ff && vec_ff == `CETU_VEC_TRACE); // RL11

endmodule // cetu_exception_unit

// File: tb/cetu_exception_unit_props.sv
`timescale 1ns/1ps
`include "cetu_defines.vh"
module cetu_exception_unit_props (
    // Inputs
    input logic        i_clk_sys, i_rst, i_insn_start, i_insn_illegal,
    input logic        i_insn_priv, i_insn_fpu, i_insn_stop, i_insn_rte, i_exc_ack,
    input logic [31:0] i_insn_pc, i_insn_next_pc, i_vbr,
    input logic [3:0]  i_rte_format,
    input logic [15:0] i_status_word, i_stop_status_word,
    // Outputs
    input logic        o_exc_valid, o_stop_enter, o_irq_hold,
    input logic [7:0]  o_vector,
    input logic [9:0]  o_vec_offset,
    input logic [31:0] o_vec_addr, o_frame_pc, o_frame_fault_pc,
    input logic [3:0]  o_frame_format,
    input logic [15:0] o_frame_status_word, o_new_status_word
);
    localparam logic [15:0] OK_FMT = `CETU_FMT_OK_MASK;
    wire go  = i_insn_start && !o_exc_valid && !i_insn_illegal;
    wire sup = i_status_word[`CETU_SR_SUPER];
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_priv_vector: assert property (go && i_insn_priv && !sup |=> o_exc_valid &&
        o_vector == `CETU_VEC_PRIV && o_frame_pc == $past(i_insn_pc)) else $error("priv frame");
    a_fp_frame: assert property (go && i_insn_fpu && !i_insn_priv |=>
        o_vector == `CETU_VEC_FLINE && o_frame_format == `CETU_FMT_FPEXT &&
        o_frame_pc == $past(i_insn_next_pc) && o_frame_fault_pc == $past(i_insn_pc))
        else $error("fp frame");
    a_format_err: assert property (go && i_insn_rte && sup && !OK_FMT[i_rte_format] |=>
        o_vector == `CETU_VEC_FORMAT && o_frame_format == `CETU_FMT_NORMAL &&
        o_frame_pc == $past(i_insn_pc)) else $error("format error frame");
    a_offset_x4: assert property (o_exc_valid |-> o_vec_offset == {o_vector, 2'b00} &&
        o_vec_addr == i_vbr + {22'h0, o_vec_offset}) else $error("vector offset");
    a_new_sr: assert property (o_exc_valid |->
        o_new_status_word == {3'b001, o_frame_status_word[12:0]}) else $error("new status");
    a_trace_irq: assert property (o_exc_valid && o_vector == `CETU_VEC_TRACE |-> o_irq_hold)
        else $error("irq hold");
    a_req_stands: assert property (o_exc_valid && !i_exc_ack |=> o_exc_valid &&
        $stable(o_vector) && $stable(o_frame_pc)) else $error("request dropped");
    a_ack_clears: assert property (o_exc_valid && i_exc_ack |=> !o_exc_valid)
        else $error("ack ignored");
    a_illegal_quiet: assert property (i_insn_start && i_insn_illegal && !o_exc_valid |=>
        !o_exc_valid) else $error("illegal traced");
    a_traced_stop: assert property (go && i_insn_stop && sup &&
        i_status_word[15:14] == `CETU_TR_ALL |=> o_exc_valid && !o_stop_enter &&
        o_vector == `CETU_VEC_TRACE && o_frame_status_word == $past(i_stop_status_word))
        else $error("traced stop");
    a_stop_pulse: assert property (o_stop_enter |=> !o_stop_enter) else $error("stop pulse");
endmodule // cetu_exception_unit_props

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "cetu_defines.vh"
module testbench;
    typedef struct packed {
        logic [5:0] f; // priv fpu stop rte illegal flow
        logic [2:0] sr;
        logic [3:0] fmt;
        logic [7:0] vec;
    } cetu_row_t;
    localparam logic [31:0] EA = 32'h0002_0124;
    localparam logic [15:0] STOP_SR = 16'h8715;
    localparam logic [15:0] OK_FMT = `CETU_FMT_OK_MASK;
    localparam logic [5:0] P_DONE = 6'h10, P_SUSP = 6'h08, P_RES = 6'h04, P_FDN = 6'h02;
    logic        i_clk_sys, i_rst, i_insn_start, i_insn_illegal, i_insn_priv, i_insn_fpu;
    logic        i_insn_flow, i_insn_stop, i_insn_rte, i_ea_needed, i_insn_done;
    logic        i_insn_suspend, i_insn_resume, i_forced_exc, i_forced_done, i_exc_ack;
    logic        o_exc_valid, o_stop_enter, o_irq_hold;
    logic [3:0]  i_rte_format, o_frame_format;
    logic [7:0]  o_vector;
    logic [9:0]  o_vec_offset;
    logic [15:0] i_status_word, i_stop_status_word, o_frame_status_word, o_new_status_word;
    logic [31:0] i_insn_pc, i_insn_next_pc, i_ea_base, i_ea_disp, i_vbr, o_vec_addr;
    logic [31:0] o_frame_pc, o_frame_ea, o_frame_fault_pc;
    int          n_errors = 0;
    int          n_checks = 0;
    cetu_row_t   rows [12] = '{'{6'h20, 3'b000, 4'h0, 8'h08}, '{6'h20, 3'b100, 4'h0, 8'h08},
        '{6'h10, 3'b001, 4'h0, 8'h0B}, '{6'h04, 3'b001, 4'h5, 8'h0E},
        '{6'h02, 3'b101, 4'h0, 8'h00}, '{6'h08, 3'b101, 4'h0, 8'h09},
        '{6'h08, 3'b001, 4'h0, 8'h00}, '{6'h01, 3'b011, 4'h0, 8'h09},
        '{6'h00, 3'b011, 4'h0, 8'h00}, '{6'h00, 3'b101, 4'h0, 8'h09},
        '{6'h01, 3'b111, 4'h0, 8'h00}, '{6'h01, 3'b001, 4'h0, 8'h00}};

    cetu_exception_unit dut_u (.*);

    task tick;
        @(posedge i_clk_sys);
    endtask

    task close_out;
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Strobes: start done suspend resume forced_done ack
    task pulse(input logic [5:0] m);
        {i_insn_start, i_insn_done, i_insn_suspend, i_insn_resume, i_forced_done, i_exc_ack} <= m;
        tick;
    endtask

    task go(input cetu_row_t r, input int i);
        i_insn_pc <= 32'h1000 + 32'(i) * 32'h10;
        i_insn_next_pc <= 32'h1004 + 32'(i) * 32'h10;
        {i_insn_priv, i_insn_fpu, i_insn_stop, i_insn_rte, i_insn_illegal, i_insn_flow} <= r.f;
        i_ea_needed <= r.f[4];
        i_status_word <= {r.sr, 13'h0};
        i_rte_format <= r.fmt;
        pulse(6'h20);
    endtask

    task run(input cetu_row_t r, input int i);
        logic [15:0] sr;
        sr = r.f[3] ? STOP_SR : {r.sr, 13'h0};
        go(r, i);
        if (!r.f[3] && !r.f[1] && (r.vec == 8'h00 || r.vec == 8'h09)) pulse(P_DONE);
        #1;
        chk(o_exc_valid, r.vec != 8'h00);
        chk(o_stop_enter, r.f[3] && r.vec == 8'h00);
        if (r.vec != 8'h00) begin
            chk(o_vector, r.vec);
            chk(o_vec_addr, 32'h4000 + {r.vec, 2'b00});
            chk(o_frame_pc, (r.vec == 8'h08 || r.vec == 8'h0E) ? i_insn_pc : i_insn_next_pc);
            chk(o_frame_status_word, sr);
            chk(o_new_status_word, {3'b001, sr[12:0]});
            chk(o_frame_format, r.f[4] ? 4'h4 : 4'h0);
            chk(o_frame_ea, r.f[4] ? EA : 32'h0);
            chk(o_frame_fault_pc, r.f[4] ? i_insn_pc : 32'h0);
            pulse(6'h01);
        end
    endtask

    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    initial begin
        repeat (5000) tick;
        n_errors++;
        close_out;
    end

    initial begin
        {i_insn_start, i_insn_illegal, i_insn_priv, i_insn_fpu, i_insn_flow, i_insn_stop} = 0;
        {i_insn_rte, i_ea_needed, i_insn_done, i_insn_suspend, i_insn_resume, i_exc_ack} = 0;
        {i_forced_exc, i_forced_done, i_rte_format, i_status_word, i_insn_pc, i_insn_next_pc} = 0;
        i_ea_base = 32'h0002_0000;
        i_ea_disp = EA - i_ea_base;
        i_stop_status_word = STOP_SR;
        i_vbr = 32'h0000_4000;
        i_rst = 1'b1;
        repeat (3) tick;
        i_rst <= 1'b0;
        #1;
        chk(o_new_status_word, 16'h2000);
        chk(o_exc_valid, 1'b0);
        foreach (rows[i]) run(rows[i], i);
        for (int k = 0; k < 16; k++)
            run(cetu_row_t'{6'h04, 3'b001, 4'(k), OK_FMT[k] ? 8'h00 : 8'h0E}, k);
        // Trace bits dropped after start, suspend in mid-run
        go(cetu_row_t'{6'h00, 3'b101, 4'h0, 8'h00}, 30);
        i_status_word <= 16'h0000;
        pulse(P_SUSP);
        pulse(P_DONE);
        pulse(P_RES);
        #1;
        chk(o_exc_valid, 1'b0);
        chk(o_irq_hold, 1'b1);
        pulse(P_DONE);
        #1;
        chk(o_vector & {8{o_exc_valid}}, 8'h09);
        chk(o_frame_status_word, 16'h0000);
        chk(o_irq_hold, 1'b1);
        pulse(6'h01);
        #1;
        chk(o_irq_hold, 1'b0);
        // Traced instruction forcing its own exception
        go(cetu_row_t'{6'h01, 3'b011, 4'h0, 8'h00}, 31);
        i_forced_exc <= 1'b1;
        pulse(P_DONE);
        i_forced_exc <= 1'b0;
        pulse(6'h00);
        #1;
        chk(o_exc_valid, 1'b0);
        pulse(P_FDN);
        #1;
        chk(o_vector & {8{o_exc_valid}}, 8'h09);
        pulse(6'h01);
        close_out;
    end
endmodule // testbench

bind cetu_exception_unit cetu_exception_unit_props props_u (.*);
